// ---- hdl/tal_core.sv ----
// Register bank, conversion sequencing and alarm logic of the temperature sensor.
// Assumes a serial slave engine on bus_clk that issues one request at a time
// while bus_ready is high, and an analog converter whose code is steady on ref_clk.
//
// Operation
// - A pointer register selects which of six data registers is accessed.
// - Temperature is a read-only 13-bit two's-complement value, 0.0625 C per step.
// - Lowest three temperature register bits carry status flags.
// - Conversions run continuously, one every 500 ms, restarted by a temperature register read.
// - Reading the temperature register aborts the conversion in progress.
// - Above upper or overheat, or below lower, counts as a fault in the queue.
// - Queue depth is one after reset, four when the queue enable bit is set.
// - An in-tolerance result while faults are watched clears the queue.
// - Queue clears at reset and in shutdown; only reset also deasserts the alarms.
// - Open-drain alarm output with selectable polarity and comparator or interrupt mode.
// - Interrupt mode asserts on upper or lower fault, held until any register read ends with its stop.
// - After the clearing read, interrupt mode watches the hysteresis crossing, queued.
// - Comparator mode asserts when consecutive faults equal the queue depth.
// - Comparator mode releases after queued results pass the hysteresis level.
// - Overheat output is always comparator mode, asserted above the overheat limit.
// - Overheat output releases only below overheat limit minus hysteresis.
// - With the queue enabled, overheat needs queued results to assert and release.
// - Shutdown bit written high stops conversions; bus and reset keep working.
// - In shutdown the temperature register keeps the last result for reads.
// - Entering shutdown freezes both alarm outputs and holds the queue in reset.
// - After shutdown the last result stays until a new conversion completes.
// - Configuration is 8-bit read/write; limits and hysteresis are 16-bit read/write.
// - Config bits: shutdown, interrupt mode, two polarities, depth four, timeout; 7:6 zero.
// - Pointer 0 temperature, 1 config, 2 hysteresis, 3 overheat, 4 lower, 5 upper.
// - Temperature bits 2, 1, 0 flag overheat, upper and lower limits.
// - Limits hold signed 9-bit degrees in bits 15:7; bits 6:0 read zero.
module tal_core
  import tal_pkg::*;
#(
  parameter int unsigned CONV_CYC = TAL_CONV_CYC  // Cycles per conversion
) (
  input  wire logic        ref_clk,       // Core clock, 200 MHz
  input  wire logic        rst_n,         // Synchronous reset, active low
  input  wire logic        bus_clk,       // Serial engine clock
  input  wire tal_req_s    bus_req_data,  // Request kind and data word
  input  wire logic        bus_req,       // Request strobe, one bus_clk cycle
  output logic             bus_ready,     // Link idle, new request allowed
  output logic             bus_rd_valid,  // Read answer strobe
  output logic [15:0]      bus_rd_data,   // Read answer word
  input  wire logic [12:0] adc_code,      // Converter result, sign and 12 bits
  output logic             adc_run,       // Converter powered
  output logic             adc_restart,   // Conversion restart pulse
  output logic             alert_out,     // Alarm pin output level, always 0
  output logic             alert_oe_n,    // Alarm pin drive enable, low drives
  output logic             overheat_out,  // Overheat pin output level, always 0
  output logic             overheat_oe_n, // Overheat pin drive enable, low drives
  output logic             timeout_dis    // Bus timeout disable to serial engine
);

  // Signed comparison helpers: both scaled to 1/128 C in 18 bits
  function automatic logic signed [17:0] lim_fx(input logic [15:0] r);
    lim_fx = {{2{r[15]}}, r[15:7], 7'h00};
  endfunction

  function automatic logic signed [17:0] tmp_fx(input logic [12:0] c);
    tmp_fx = {{2{c[12]}}, c, 3'h0};
  endfunction

  // ---------------- Link domain ----------------
  logic       brst_meta_q, brst_n_q;
  logic       req_tgl_q;
  tal_req_s   req_hold_q;
  logic       ack_meta_q, ack_sync_q, ack_seen_q;
  logic       ack_tgl_q;
  logic [15:0] rd_word_q;

  // Reset brought into the link domain through two flops
  always_ff @(posedge bus_clk) begin
    brst_meta_q <= rst_n;
    brst_n_q    <= brst_meta_q;
  end

  // Request held stable while the toggle crosses over
  always_ff @(posedge bus_clk) begin
    if (!brst_n_q) begin
      req_tgl_q  <= 1'b0;
      req_hold_q <= '{kind: TAL_K_PTR, data: 16'h0000};
    end else if (bus_req && bus_ready) begin
      req_tgl_q  <= ~req_tgl_q;
      req_hold_q <= bus_req_data;
    end
  end

  // Answer toggle back, read word captured when it lands
  always_ff @(posedge bus_clk) begin
    if (!brst_n_q) begin
      ack_meta_q   <= 1'b0;
      ack_sync_q   <= 1'b0;
      ack_seen_q   <= 1'b0;
      bus_rd_valid <= 1'b0;
      bus_rd_data  <= 16'h0000;
    end else begin
      ack_meta_q   <= ack_tgl_q;
      ack_sync_q   <= ack_meta_q;
      ack_seen_q   <= ack_sync_q;
      bus_rd_valid <= (ack_sync_q != ack_seen_q) && (req_hold_q.kind == TAL_K_RD);
      if (ack_sync_q != ack_seen_q) begin
        bus_rd_data <= rd_word_q;
      end
    end
  end

  // One request in flight at a time
  assign bus_ready = (req_tgl_q == ack_seen_q) && brst_n_q;

  // ---------------- Core domain ----------------
  logic        rq_meta_q, rq_sync_q, rq_seen_q;
  logic [2:0]  ptr_q;
  logic [7:0]  cfg_q;
  logic [15:0] temp_q, hyst_q, ovht_q, low_q, high_q;
  logic        rd_seen_q;
  logic [31:0] conv_cnt_q;
  tal_alarm_e  a_state_q;
  logic        a_cause_hi_q;
  logic [2:0]  a_cnt_q;
  logic        ot_act_q;
  logic [2:0]  ot_cnt_q;
  logic        alert_drv_q, ot_drv_q;

  // Request toggle synchronised; the second flop is compared with the third
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rq_meta_q <= 1'b0;
      rq_sync_q <= 1'b0;
      rq_seen_q <= 1'b0;
    end else begin
      rq_meta_q <= req_tgl_q;
      rq_sync_q <= rq_meta_q;
      rq_seen_q <= rq_sync_q;
    end
  end

  // Request decode; payload is steady by the time the toggle is seen
  wire take      = rq_sync_q != rq_seen_q;
  wire take_ptr  = take && (req_hold_q.kind == TAL_K_PTR);
  wire take_wr   = take && (req_hold_q.kind == TAL_K_WR);
  wire take_rd   = take && (req_hold_q.kind == TAL_K_RD);
  wire take_stop = take && (req_hold_q.kind == TAL_K_STOP);
  wire [15:0] wdat = req_hold_q.data;
  wire shdn      = cfg_q[TAL_CFG_SHDN];
  wire int_mode  = cfg_q[TAL_CFG_INTMODE];
  wire [2:0] depth = cfg_q[TAL_CFG_FQ_EN] ? TAL_DEPTH_FOUR : TAL_DEPTH_ONE;
  wire rd_temp   = take_rd && (ptr_q == TAL_PTR_TEMP);

  // Read selection by pointer; unused pointers read zero
  logic [15:0] rd_mux;
  always_comb begin
    case (ptr_q)
      TAL_PTR_TEMP: rd_mux = temp_q;
      TAL_PTR_CFG:  rd_mux = {8'h00, cfg_q};
      TAL_PTR_HYST: rd_mux = hyst_q;
      TAL_PTR_OVHT: rd_mux = ovht_q;
      TAL_PTR_LOW:  rd_mux = low_q;
      TAL_PTR_HIGH: rd_mux = high_q;
      default:      rd_mux = 16'h0000;
    endcase
  end

  // Pointer, register writes and read answers
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ptr_q     <= TAL_PTR_TEMP;
      cfg_q     <= TAL_RST_CFG;
      hyst_q    <= TAL_RST_HYST;
      ovht_q    <= TAL_RST_OVHT;
      low_q     <= TAL_RST_LOW;
      high_q    <= TAL_RST_HIGH;
      ack_tgl_q <= 1'b0;
      rd_word_q <= 16'h0000;
    end else begin
      if (take) begin
        ack_tgl_q <= ~ack_tgl_q;
      end
      if (take_ptr) begin
        ptr_q <= wdat[2:0];
      end
      if (take_rd) begin
        rd_word_q <= rd_mux;
      end
      if (take_wr) begin
        case (ptr_q)
          TAL_PTR_CFG:  cfg_q  <= wdat[7:0] & TAL_CFG_WMASK;
          TAL_PTR_HYST: hyst_q <= wdat & TAL_LIM_MASK;
          TAL_PTR_OVHT: ovht_q <= wdat & TAL_LIM_MASK;
          TAL_PTR_LOW:  low_q  <= wdat & TAL_LIM_MASK;
          TAL_PTR_HIGH: high_q <= wdat & TAL_LIM_MASK;
          default:      ;                            // Temperature is read-only
        endcase
      end
    end
  end

  // Read pending until its stop; any register counts
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rd_seen_q <= 1'b0;
    end else if (take_rd) begin
      rd_seen_q <= 1'b1;
    end else if (take_stop) begin
      rd_seen_q <= 1'b0;
    end
  end
  wire rd_done = take_stop && rd_seen_q;

  // Conversion timebase; a temperature read restarts it
  wire conv_done = !shdn && (conv_cnt_q == 32'(CONV_CYC - 1));
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      conv_cnt_q  <= 32'h0000_0000;
      adc_restart <= 1'b0;
    end else begin
      adc_restart <= rd_temp && !shdn;
      if (shdn) begin
        conv_cnt_q <= conv_cnt_q;
      end else if (rd_temp || conv_done) begin
        conv_cnt_q <= 32'h0000_0000;
      end else begin
        conv_cnt_q <= conv_cnt_q + 32'h0000_0001;
      end
    end
  end
  assign adc_run = !shdn;

  // Comparisons of the fresh result against the limits
  wire signed [17:0] t_new  = tmp_fx(adc_code);
  wire signed [17:0] hy     = lim_fx(hyst_q);
  wire hi_f   = t_new > lim_fx(high_q);
  wire lo_f   = t_new < lim_fx(low_q);
  wire ot_f   = t_new > lim_fx(ovht_q);
  wire rel_hi = t_new < (lim_fx(high_q) - hy);
  wire rel_lo = t_new > (lim_fx(low_q) + hy);
  wire rel_ot = t_new < (lim_fx(ovht_q) - hy);

  // Result and flags change only on a finished conversion
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      temp_q <= TAL_RST_TEMP;
    end else if (conv_done) begin
      temp_q <= {adc_code, ot_f, hi_f, lo_f};
    end
  end

  // Alarm queue: condition watched depends on the sequencing state
  wire a_trip  = hi_f || lo_f;
  wire a_rel   = a_cause_hi_q ? rel_hi : rel_lo;
  wire a_watch = (a_state_q == TAL_A_WATCH_FAULT) ? a_trip :
                 (a_state_q == TAL_A_WATCH_HYST)  ? a_rel : 1'b0;
  wire a_full  = (a_cnt_q + 3'h1) >= depth;

  // Alarm sequencing, comparator and interrupt modes share one path
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      a_state_q    <= TAL_A_WATCH_FAULT;
      a_cause_hi_q <= 1'b0;
      a_cnt_q      <= 3'h0;
    end else if (shdn) begin
      a_cnt_q <= 3'h0;
    end else begin
      if (conv_done) begin
        if (!a_watch) begin
          a_cnt_q <= 3'h0;
        end else if (!a_full) begin
          a_cnt_q <= a_cnt_q + 3'h1;
        end else begin
          a_cnt_q <= 3'h0;
          case (a_state_q)
            TAL_A_WATCH_FAULT: begin
              a_cause_hi_q <= hi_f;
              a_state_q    <= int_mode ? TAL_A_PEND_FAULT : TAL_A_WATCH_HYST;
            end
            TAL_A_WATCH_HYST:
              a_state_q <= int_mode ? TAL_A_PEND_HYST : TAL_A_WATCH_FAULT;
            default: a_state_q <= a_state_q;
          endcase
        end
      end
      if (rd_done) begin
        case (a_state_q)
          TAL_A_PEND_FAULT: a_state_q <= TAL_A_WATCH_HYST;
          TAL_A_PEND_HYST:  a_state_q <= TAL_A_WATCH_FAULT;
          default:          a_state_q <= a_state_q;
        endcase
      end
    end
  end

  // Overheat queue, always comparator behaviour
  wire ot_watch = ot_act_q ? rel_ot : ot_f;
  wire ot_full  = (ot_cnt_q + 3'h1) >= depth;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ot_act_q <= 1'b0;
      ot_cnt_q <= 3'h0;
    end else if (shdn) begin
      ot_cnt_q <= 3'h0;
    end else if (conv_done) begin
      if (!ot_watch) begin
        ot_cnt_q <= 3'h0;
      end else if (!ot_full) begin
        ot_cnt_q <= ot_cnt_q + 3'h1;
      end else begin
        ot_cnt_q <= 3'h0;
        ot_act_q <= ~ot_act_q;
      end
    end
  end

  // Asserted alarm levels before polarity
  wire alert_act = (a_state_q == TAL_A_PEND_FAULT) || (a_state_q == TAL_A_PEND_HYST) ||
                   (!int_mode && (a_state_q == TAL_A_WATCH_HYST));

  // Pin drives: open drain pulls low for the low level; frozen in shutdown
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      alert_drv_q <= 1'b0;
      ot_drv_q    <= 1'b0;
    end else if (!shdn) begin
      alert_drv_q <= alert_act ^ cfg_q[TAL_CFG_ALRT_POL];
      ot_drv_q    <= ot_act_q  ^ cfg_q[TAL_CFG_OVHT_POL];
    end
  end

  // Drive low is the only active level of an open-drain pin
  assign alert_out     = 1'b0;
  assign alert_oe_n    = ~alert_drv_q;
  assign overheat_out  = 1'b0;
  assign overheat_oe_n = ~ot_drv_q;
  assign timeout_dis   = cfg_q[TAL_CFG_TO_DIS];

  // ---------------- Checks ----------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  AST_READ_TEMP: assert property (rd_temp |=> rd_word_q == $past(temp_q))
    else $error("temperature read returned wrong word");

  AST_LIMIT_LOW_ZERO: assert property ((hyst_q[6:0] | high_q[6:0] | low_q[6:0] | ovht_q[6:0]) == 7'h00)
    else $error("limit low bits not zero");

  AST_CFG_RSVD: assert property (cfg_q[7:6] == 2'h0)
    else $error("reserved config bits set");

  AST_CONV_BOUND: assert property (conv_cnt_q < CONV_CYC)
    else $error("conversion counter past period");

  AST_ABORT: assert property (rd_temp && !shdn |=> conv_cnt_q == 32'h0000_0000 && adc_restart == 1'b1 ##1 adc_restart == 1'b0)
    else $error("temperature read did not restart conversion");

  AST_SD_HOLD: assert property (shdn && $past(shdn) |-> $stable(temp_q) && a_cnt_q == 3'h0)
    else $error("result or queue moved in shutdown");

  AST_SD_FREEZE: assert property (shdn ##1 shdn |-> $stable(alert_oe_n) && $stable(overheat_oe_n))
    else $error("alarm pins moved in shutdown");

  AST_QUEUE_DEPTH: assert property (a_cnt_q < depth && ot_cnt_q < depth)
    else $error("queue count reached depth");

  AST_INT_CLEAR: assert property (rd_done && a_state_q == TAL_A_PEND_FAULT && !shdn
                                  |=> !alert_act ##1 alert_oe_n == !cfg_q[TAL_CFG_ALRT_POL])
    else $error("interrupt alarm not cleared by read");

  AST_CMP_SET: assert property (conv_done && !int_mode && a_state_q == TAL_A_WATCH_FAULT && a_trip
                                && a_cnt_q == depth - 3'h1 |=> alert_act)
    else $error("comparator alarm missed at queue depth");

  AST_OT_SET: assert property (conv_done && !ot_act_q && ot_f && ot_cnt_q == depth - 3'h1 |=> ot_act_q)
    else $error("overheat missed");

endmodule

// ---- include/tal_pkg.sv ----
// Package of the temperature alarm block: register map, field positions,
// reset values, conversion timing and the request carrier of the serial side.
// Assumes a serial slave engine outside that decodes frames into requests.
package tal_pkg;

  // Pointer values
  localparam logic [2:0] TAL_PTR_TEMP  = 3'h0;
  localparam logic [2:0] TAL_PTR_CFG   = 3'h1;
  localparam logic [2:0] TAL_PTR_HYST  = 3'h2;
  localparam logic [2:0] TAL_PTR_OVHT  = 3'h3;
  localparam logic [2:0] TAL_PTR_LOW   = 3'h4;
  localparam logic [2:0] TAL_PTR_HIGH  = 3'h5;

  // Configuration bit positions
  localparam int TAL_CFG_SHDN     = 0;
  localparam int TAL_CFG_INTMODE  = 1;
  localparam int TAL_CFG_OVHT_POL = 2;
  localparam int TAL_CFG_ALRT_POL = 3;
  localparam int TAL_CFG_FQ_EN    = 4;
  localparam int TAL_CFG_TO_DIS   = 5;
  localparam logic [7:0] TAL_CFG_WMASK = 8'h3F;

  // Temperature register layout
  localparam int TAL_TEMP_LSB   = 3;
  localparam int TAL_FLAG_OVHT  = 2;
  localparam int TAL_FLAG_HIGH  = 1;
  localparam int TAL_FLAG_LOW   = 0;
  localparam logic [15:0] TAL_LIM_MASK = 16'hFF80;

  // Values after reset
  localparam logic [15:0] TAL_RST_TEMP = 16'h0000;
  localparam logic [7:0]  TAL_RST_CFG  = 8'h00;
  localparam logic [15:0] TAL_RST_HYST = 16'h0100;
  localparam logic [15:0] TAL_RST_OVHT = 16'h2800;
  localparam logic [15:0] TAL_RST_LOW  = 16'h0500;
  localparam logic [15:0] TAL_RST_HIGH = 16'h2000;

  // Fault queue depths
  localparam logic [2:0] TAL_DEPTH_ONE  = 3'h1;
  localparam logic [2:0] TAL_DEPTH_FOUR = 3'h4;

  // Conversion timebase
  localparam int unsigned TAL_CONV_MS  = 500;
  localparam int unsigned TAL_CLK_MHZ  = 200;
  localparam int unsigned TAL_CONV_CYC = TAL_CONV_MS * 1000 * TAL_CLK_MHZ;

  // Request kinds from the serial engine
  typedef enum logic [1:0] {
    TAL_K_PTR,
    TAL_K_WR,
    TAL_K_RD,
    TAL_K_STOP
  } tal_kind_e;

  typedef struct packed {
    tal_kind_e   kind;
    logic [15:0] data;
  } tal_req_s;

  // Alarm sequencing
  typedef enum logic [1:0] {
    TAL_A_WATCH_FAULT,
    TAL_A_PEND_FAULT,
    TAL_A_WATCH_HYST,
    TAL_A_PEND_HYST
  } tal_alarm_e;

endpackage

// ---- verif/tal_host_model.sv ----
// Behavioural serial engine standing in front of the temperature alarm core.
// Assumes the core's link handshake: one strobe per request, next one after ready.
module tal_host_model
  import tal_pkg::*;
(
  input  wire logic        bus_clk,      // Link clock
  input  wire logic        bus_ready,    // Core idle
  input  wire logic        bus_rd_valid, // Read answer strobe
  input  wire logic [15:0] bus_rd_data,  // Read answer word
  output tal_req_s         bus_req_data, // Request kind and word
  output logic             bus_req       // Request strobe
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int WAIT_MAX = 64;

  // Idle link at time zero
  initial begin
    bus_req      = 1'b0;
    bus_req_data = '0;
  end

  // One request; ok stays low if the core never answers
  task automatic send(input tal_kind_e kind, input logic [15:0] data, output logic [15:0] rdata, output bit ok);
    int n;
    ok    = 1'b0;
    rdata = 16'h0000;
    for (n = 0; n < WAIT_MAX; n++) begin
      @(posedge bus_clk);
      if (bus_ready === 1'b1) break;
    end
    if (n == WAIT_MAX) return;
    #1;
    bus_req_data = '{kind: kind, data: data};
    bus_req      = 1'b1;
    @(posedge bus_clk);
    #1;
    bus_req      = 1'b0;
    // Released word shows its inverse so a stale sample cannot pass
    bus_req_data = tal_req_s'(~{kind, data});
    if (kind == TAL_K_RD) begin
      for (n = 0; n < WAIT_MAX; n++) begin
        @(posedge bus_clk);
        if (bus_rd_valid === 1'b1) break;
      end
      if (n == WAIT_MAX) return;
      rdata = bus_rd_data;
    end
    for (n = 0; n < WAIT_MAX; n++) begin
      if (bus_ready === 1'b1) break;
      @(posedge bus_clk);
    end
    ok = (n < WAIT_MAX);
  endtask
endmodule

// ---- verif/test_tal_core.sv ----
// Self-checking bench of the temperature alarm core, register access through the host model.
// Assumes a short conversion period so alarm sequences fit in a brief run.
module test_tal_core
  import tal_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int CONV = 64;

  logic        ref_clk;
  logic        bus_clk;
  logic        rst_n;
  logic [12:0] adc_code;
  tal_req_s    bus_req_data;
  logic        bus_req;
  logic        bus_ready;
  logic        bus_rd_valid;
  logic [15:0] bus_rd_data;
  logic        adc_run;
  logic        adc_restart;
  logic        alert_out;
  logic        alert_oe_n;
  logic        overheat_out;
  logic        overheat_oe_n;
  logic        timeout_dis;
  logic [15:0] v;
  logic [15:0] sink;
  int          restarts;
  logic [15:0] rst_tab [8];
  int          bad_count;
  int          comparisons;

  // Core clock 5 ns, link clock 6 ns with an unrelated phase
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  initial begin
    bus_clk = 1'b0;
    #1.3;
    forever #3 bus_clk = ~bus_clk;
  end

  tal_core #(.CONV_CYC(CONV)) u_tal_core (
    .ref_clk(ref_clk), .rst_n(rst_n), .bus_clk(bus_clk), .bus_req_data(bus_req_data),
    .bus_req(bus_req), .bus_ready(bus_ready), .bus_rd_valid(bus_rd_valid), .bus_rd_data(bus_rd_data),
    .adc_code(adc_code), .adc_run(adc_run), .adc_restart(adc_restart), .alert_out(alert_out),
    .alert_oe_n(alert_oe_n), .overheat_out(overheat_out), .overheat_oe_n(overheat_oe_n),
    .timeout_dis(timeout_dis));

  tal_host_model u_tal_host_model (
    .bus_clk(bus_clk), .bus_ready(bus_ready), .bus_rd_valid(bus_rd_valid),
    .bus_rd_data(bus_rd_data), .bus_req_data(bus_req_data), .bus_req(bus_req));

  task automatic summarize();
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Register word of a whole-degree result, flags against reset limits
  function automatic logic [15:0] exp_temp(int deg);
    logic [15:0] t;
    t = {13'(deg * 16), 3'h0};
    return {t[15:3], $signed(t) > $signed(16'h2800), $signed(t) > $signed(16'h2000), $signed(t) < $signed(16'h0500)};
  endfunction

  task automatic wait_ref(int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic set_temp(int deg);
    adc_code = 13'(deg * 16);
  endtask

  // A hung link ends the run at once
  task automatic req(input tal_kind_e kind, input logic [15:0] data, output logic [15:0] rdata);
    bit ok;
    u_tal_host_model.send(kind, data, rdata, ok);
    if (!ok) begin
      bad_count++;
      $display("[ERR] link_answer expected 1 seen 0");
      summarize();
    end
  endtask

  task automatic wr_reg(input logic [2:0] ptr, input logic [15:0] val);
    logic [15:0] d;
    req(TAL_K_PTR, {13'h0000, ptr}, d);
    req(TAL_K_WR, val, d);
    req(TAL_K_STOP, 16'h0000, d);
  endtask

  task automatic rd_reg(input logic [2:0] ptr, output logic [15:0] val);
    logic [15:0] d;
    req(TAL_K_PTR, {13'h0000, ptr}, d);
    req(TAL_K_RD, 16'h0000, val);
    req(TAL_K_STOP, 16'h0000, d);
  endtask

  // Reset long enough for the link side synchroniser as well
  task automatic do_reset();
    wait_ref(1);
    rst_n = 1'b0;
    set_temp(30);
    wait_ref(6);
    rst_n = 1'b1;
    wait_ref(2);
  endtask

  // One result, then both pins and the stored word
  task automatic step(int deg, logic ea, logic eo);
    set_temp(deg);
    wait_ref(CONV + 8);
    check("alert_oe_n", {15'h0000, alert_oe_n}, {15'h0000, ea});
    check("overheat_oe_n", {15'h0000, overheat_oe_n}, {15'h0000, eo});
    rd_reg(TAL_PTR_TEMP, v);
    check("temperature", v, exp_temp(deg));
  endtask

  // Restart pulses seen on the converter side
  always @(posedge ref_clk) begin
    if (adc_restart === 1'b1) restarts <= restarts + 1;
  end

  // Hang guard
  initial begin
    repeat (60000) @(posedge ref_clk);
    bad_count++;
    $display("[ERR] run_time expected finish seen timeout");
    summarize();
  end

  initial begin
    rst_n       = 1'b0;
    adc_code    = 13'h1E0;
    bad_count   = 0;
    comparisons = 0;
    rst_tab     = '{16'h0000, 16'h0000, 16'h0100, 16'h2800, 16'h0500, 16'h2000, 16'h0000, 16'h0000};
    do_reset();
    check("alert_rst", {15'h0000, alert_oe_n}, 16'h0001);
    check("overheat_rst", {15'h0000, overheat_oe_n}, 16'h0001);
    check("pin_levels", {14'h0000, alert_out, overheat_out}, 16'h0000);
    check("adc_run_rst", {15'h0000, adc_run}, 16'h0001);
    for (int p = 0; p < 8; p++) begin
      rd_reg(3'(p), v);
      check("reg_reset", v, rst_tab[p]);
    end
    // Read-only result, masked limits, reserved config bits
    wait_ref(CONV + 8);
    wr_reg(TAL_PTR_TEMP, 16'h1234);
    rd_reg(TAL_PTR_TEMP, v);
    check("temp_ro", v, exp_temp(30));
    for (int p = 2; p < 6; p++) begin
      wr_reg(3'(p), 16'hFFFF);
      rd_reg(3'(p), v);
      check("limit_mask", v, 16'hFF80);
    end
    wr_reg(TAL_PTR_CFG, 16'hFFFF);
    rd_reg(TAL_PTR_CFG, v);
    check("config", v, 16'h003F);
    check("timeout_dis", {15'h0000, timeout_dis}, 16'h0001);
    check("adc_run", {15'h0000, adc_run}, 16'h0000);
    // Comparator mode with depth one, upper, lower and overheat bands
    do_reset();
    step(70, 1'b0, 1'b1);
    step(63, 1'b0, 1'b1);
    step(61, 1'b1, 1'b1);
    step(-20, 1'b0, 1'b1);
    step(11, 1'b0, 1'b1);
    step(13, 1'b1, 1'b1);
    step(90, 1'b0, 1'b0);
    step(79, 1'b0, 1'b0);
    step(77, 1'b0, 1'b1);
    step(61, 1'b1, 1'b1);
    // Back-to-back reads keep aborting the conversion
    set_temp(40);
    restarts = 0;
    repeat (6) begin
      req(TAL_K_RD, 16'h0000, v);
      req(TAL_K_STOP, 16'h0000, sink);
      check("temp_hold", v, exp_temp(61));
    end
    check("restarts", 16'(restarts), 16'h0006);
    wait_ref(CONV + 8);
    rd_reg(TAL_PTR_TEMP, v);
    check("temp_new", v, exp_temp(40));
    // Depth four: one good result in the run restarts the count
    do_reset();
    wr_reg(TAL_PTR_CFG, 16'h0010);
    rd_reg(TAL_PTR_TEMP, v);
    set_temp(90);
    wait_ref(3 * CONV + 16);
    check("alert_q3", {15'h0000, alert_oe_n & overheat_oe_n}, 16'h0001);
    set_temp(30);
    wait_ref(CONV);
    set_temp(90);
    wait_ref(3 * CONV);
    check("alert_q_clr", {15'h0000, alert_oe_n & overheat_oe_n}, 16'h0001);
    wait_ref(CONV);
    check("alert_q4", {14'h0000, alert_oe_n, overheat_oe_n}, 16'h0000);
    // Interrupt mode: held until a read completes, then the hysteresis crossing
    do_reset();
    wr_reg(TAL_PTR_CFG, 16'h0002);
    set_temp(70);
    wait_ref(3 * CONV);
    check("int_set", {15'h0000, alert_oe_n}, 16'h0000);
    req(TAL_K_PTR, {13'h0000, TAL_PTR_CFG}, v);
    req(TAL_K_RD, 16'h0000, v);
    check("int_mid_read", {15'h0000, alert_oe_n}, 16'h0000);
    req(TAL_K_STOP, 16'h0000, v);
    wait_ref(2);
    check("int_clear", {15'h0000, alert_oe_n}, 16'h0001);
    wait_ref(2 * CONV);
    check("int_no_hyst", {15'h0000, alert_oe_n}, 16'h0001);
    set_temp(50);
    wait_ref(CONV + 8);
    check("int_hyst", {15'h0000, alert_oe_n}, 16'h0000);
    rd_reg(TAL_PTR_HIGH, v);
    wait_ref(2);
    check("int_clear2", {15'h0000, alert_oe_n}, 16'h0001);
    // Active-high polarity drives the pins low while idle
    do_reset();
    wr_reg(TAL_PTR_CFG, 16'h000C);
    wait_ref(4);
    check("pol_idle", {14'h0000, alert_oe_n, overheat_oe_n}, 16'h0000);
    set_temp(90);
    wait_ref(CONV + 8);
    check("pol_active", {14'h0000, alert_oe_n, overheat_oe_n}, 16'h0003);
    // Shutdown freezes result and alarm pin, resumes on the next conversion
    do_reset();
    set_temp(70);
    wait_ref(CONV + 8);
    wr_reg(TAL_PTR_CFG, 16'h0001);
    check("sd_adc_run", {15'h0000, adc_run}, 16'h0000);
    set_temp(20);
    wait_ref(3 * CONV);
    rd_reg(TAL_PTR_TEMP, v);
    check("sd_temp", v, exp_temp(70));
    check("sd_alert", {15'h0000, alert_oe_n}, 16'h0000);
    wr_reg(TAL_PTR_CFG, 16'h0000);
    rd_reg(TAL_PTR_TEMP, v);
    check("wake_temp", v, exp_temp(70));
    wait_ref(CONV + 8);
    rd_reg(TAL_PTR_TEMP, v);
    check("wake_new", v, exp_temp(20));
    check("wake_alert", {15'h0000, alert_oe_n}, 16'h0001);
    summarize();
  end
endmodule
